// ===== hw/vfr_pkg.sv
// Shared constants for the window resize block and its requester
package vfr_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          NUM_WIN       = 6;
  localparam int          NUM_RSZ       = 2;
  // Function configuration map (byte addresses)
  localparam logic [11:0] OFF_VF_CTRL   = 12'h008;
  localparam logic [11:0] OFF_PAGE_SUP  = 12'h01C;
  localparam logic [11:0] OFF_PAGE_SIZE = 12'h020;
  localparam logic [11:0] OFF_WIN0      = 12'h024;
  localparam logic [11:0] OFF_WIN_LAST  = 12'h038;
  localparam logic [11:0] OFF_RSZ_HDR   = 12'h200;
  localparam logic [11:0] OFF_RSZ_CAP0  = 12'h204;
  localparam logic [11:0] OFF_RSZ_CTRL0 = 12'h208;
  localparam logic [11:0] RSZ_STRIDE    = 12'h008;
  // Extended capability header fields
  localparam logic [11:0] CAP_ID        = 12'h024;
  localparam logic [3:0]  CAP_VER       = 4'h1;
  localparam logic [15:0] CAP_NEXT      = 16'h0000;
  // VF control bits
  localparam int          VF_EN_BIT     = 0;
  localparam int          MSE_BIT       = 3;
  // Resize control fields
  localparam int          IDX_LSB       = 0;
  localparam int          CNT_LSB       = 5;
  localparam int          CODE_LSB      = 8;
  localparam int          CODE_W        = 6;
  localparam logic [5:0]  CODE_MAX      = 6'h2B;
  localparam logic [5:0]  CODE_RST      = 6'h00;
  localparam logic [2:0]  RSZ_COUNT     = 3'h2;
  // Size encodings, as base two logarithms
  localparam logic [6:0]  SIZE_LOG0     = 7'h14;
  localparam logic [6:0]  PAGE_LOG0     = 7'h0C;
  localparam int          PAGE_BITS     = 20;
  // Supported sizes: 1 MB to 8 MB, all below 4 GB
  localparam logic [31:0] RSZ_CAP_VAL   = 32'h0000_00F0;
  localparam logic [31:0] PAGE_SUP_VAL  = 32'h0000_0013;
  localparam logic [31:0] PAGE_RST      = 32'h0000_0001;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] BASE_RST      = 32'h0000_0000;
  // Low window bits: 32-bit memory type, read-only
  localparam logic [31:0] TYPE_MASK     = 32'h0000_000F;
  localparam logic [31:0] TYPE_VAL      = 32'h0000_0000;
  // Requester registers on APB
  localparam logic [11:0] H_ADDR        = 12'h000;
  localparam logic [11:0] H_WDATA       = 12'h004;
  localparam logic [11:0] H_CMD         = 12'h008;
  localparam logic [11:0] H_STAT        = 12'h00C;
  localparam logic [11:0] H_RDATA       = 12'h010;
  localparam int          CMD_GO        = 0;
  localparam int          CMD_WR        = 1;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_CFG_ERR    = 1;
  localparam int          ST_MSE_ERR    = 2;
  localparam int          ST_PAGE_WARN  = 3;
  localparam int          ST_BASE_PEND  = 4;
endpackage

// ===== hw/vfr_cfg_if.sv
// Configuration access channel between requester and function
`timescale 1ns/10ps
interface vfr_cfg_if (
  input wire logic clk,    // Function clock
  input wire logic rst_n   // Conventional reset
);
  logic        cfg_req;    // Request held until ack
  logic        cfg_write;  // 1 write, 0 read
  logic [11:0] cfg_addr;   // Byte address
  logic [31:0] cfg_wdata;  // Write data
  logic [31:0] cfg_rdata;  // Read data, valid with ack
  logic        cfg_ack;    // One-cycle completion
  logic        cfg_err;    // Unmapped address, with ack

  modport dev (
    input  cfg_req, cfg_write, cfg_addr, cfg_wdata,
    output cfg_rdata, cfg_ack, cfg_err
  );
  modport host (
    output cfg_req, cfg_write, cfg_addr, cfg_wdata,
    input  cfg_rdata, cfg_ack, cfg_err
  );
endinterface

// ===== hw/vfr_window_mask.sv
// Read-only mask of one window from page size and size code
`timescale 1ns/10ps
module vfr_window_mask
  import vfr_pkg::*;
(
  input  wire logic [31:0] page_size,  // Page size register
  input  wire logic [5:0]  size_code,  // Chosen size code
  output logic      [31:0] ro_mask     // Ones on read-only bits
);
  logic [6:0] page_log;
  logic [6:0] code_log;
  logic [6:0] eff_log;

  // Highest set page bit wins; bad writes still decode
  always_comb begin
    page_log = PAGE_LOG0;
    for (int i = 0; i < PAGE_BITS; i++) begin
      if (page_size[i]) begin
        page_log = PAGE_LOG0 + 7'(i);
      end
    end
  end

  // Larger of page and code sizes
  always_comb begin
    code_log = SIZE_LOG0 + {1'b0, size_code};
    eff_log  = (page_log > code_log) ? page_log : code_log;
  end

  // Contiguous run of low ones
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      ro_mask[i] = (7'(i) < eff_log);
    end
  end
endmodule

// ===== hw/vfr_dev.sv
// Function end: window registers and resize capability
//
// Design decisions made here: the config channel interface to the registers and the address map.
`timescale 1ns/10ps
module vfr_dev
  import vfr_pkg::*;
(
  vfr_cfg_if.dev                      cfg,              // Config port
  input  wire logic                   clk,              // 25 MHz clock
  input  wire logic                   rst_n,            // Async reset
  input  wire logic                   per_function_reset, // VF reset
  output logic                        vf_reset_done,    // VF reset taken
  output logic                        vf_memory_space_enable, // Enable
  output logic [NUM_WIN-1:0][31:0]    vf_window_base_n, // Decoded bases
  output logic [NUM_WIN-1:0][31:0]    vf_window_mask    // Read-only bits
);
  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0]                  ctrl_reg;
  logic [31:0]                  page_reg;
  logic [NUM_WIN-1:0][31:0]     base_reg;
  logic [NUM_RSZ-1:0][5:0]      code_reg;
  logic [NUM_WIN-1:0][5:0]      win_code;
  logic [NUM_WIN-1:0][31:0]     ro_mask;
  logic                         ack_reg;
  logic [31:0]                  rdata_reg;
  logic                         err_reg;
  logic                         vf_done_reg;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic        take;
  logic        wr;
  logic        hit;
  logic [31:0] rd_val;
  logic        win_hit;
  logic [2:0]  win_idx;
  logic        rsz_hit;
  logic        rsz_ctl;
  logic [2:0]  rsz_idx;
  logic [11:0] win_off;
  logic [11:0] rsz_off;

  // One access per request; ack drops the request
  assign take = cfg.cfg_req & ~ack_reg;
  assign wr   = take & cfg.cfg_write;

  // Window and resize slot selection
  always_comb begin
    win_off = cfg.cfg_addr - OFF_WIN0;
    rsz_off = cfg.cfg_addr - OFF_RSZ_CAP0;
    win_idx = win_off[4:2];
    rsz_idx = rsz_off[5:3];
    rsz_ctl = rsz_off[2];
    win_hit = (cfg.cfg_addr >= OFF_WIN0) &&
              (cfg.cfg_addr <= OFF_WIN_LAST) &&
              (cfg.cfg_addr[1:0] == 2'b00);
    rsz_hit = (cfg.cfg_addr >= OFF_RSZ_CAP0) &&
              (rsz_off[11:3] < 9'(NUM_RSZ)) &&
              (cfg.cfg_addr[1:0] == 2'b00);
  end

  ////////////////////////////////////////////////////////////////////////
  // Masks per window
  // Unresized windows keep the default code
  always_comb begin
    for (int i = 0; i < NUM_WIN; i++) begin
      win_code[i] = (i < NUM_RSZ) ? code_reg[i] : CODE_RST;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_mask
      vfr_window_mask u_mask (
        .page_size (page_reg),
        .size_code (win_code[g]),
        .ro_mask   (ro_mask[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  // Resize block lives only in this physical function map
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (win_hit) begin
      rd_val = (base_reg[win_idx] & ~ro_mask[win_idx]) | TYPE_VAL;
    end else if (rsz_hit && !rsz_ctl) begin
      rd_val = RSZ_CAP_VAL;
    end else if (rsz_hit) begin
      rd_val[CODE_LSB +: CODE_W] = code_reg[rsz_idx];
      rd_val[IDX_LSB +: 3]       = rsz_idx;
      if (rsz_idx == 3'h0) begin
        rd_val[CNT_LSB +: 3] = RSZ_COUNT;
      end
    end else begin
      case (cfg.cfg_addr)
        OFF_VF_CTRL:   rd_val = ctrl_reg;
        OFF_PAGE_SUP:  rd_val = PAGE_SUP_VAL;
        OFF_PAGE_SIZE: rd_val = page_reg;
        OFF_RSZ_HDR:   rd_val = {CAP_ID, CAP_VER, CAP_NEXT};
        default:       hit    = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel answer
  // Registered ack, one cycle after the request is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      ack_reg <= take;
      if (take) begin
        rdata_reg <= cfg.cfg_write ? 32'h0000_0000 : rd_val;
        err_reg   <= ~hit;
      end
    end
  end

  assign cfg.cfg_ack   = ack_reg;
  assign cfg.cfg_rdata = rdata_reg;
  assign cfg.cfg_err   = err_reg;

  ////////////////////////////////////////////////////////////////////////
  // VF control and page size
  // Only enable bits are writable; rest read zero
  // Not touched by per-function reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr && cfg.cfg_addr == OFF_VF_CTRL) begin
      ctrl_reg[VF_EN_BIT] <= cfg.cfg_wdata[VF_EN_BIT];
      ctrl_reg[MSE_BIT]   <= cfg.cfg_wdata[MSE_BIT];
    end
  end

  // Page size also reshapes every mask at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= PAGE_RST;
    end else if (wr && cfg.cfg_addr == OFF_PAGE_SIZE) begin
      page_reg <= cfg.cfg_wdata & ((32'h0000_0001 << PAGE_BITS) - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Size codes
  // Stored on the completing edge; mask follows combinationally
  // Codes above the top encoding are clipped, not wrapped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= {NUM_RSZ{CODE_RST}};
    end else if (wr && rsz_hit && rsz_ctl) begin
      if (cfg.cfg_wdata[CODE_LSB +: CODE_W] > CODE_MAX) begin
        code_reg[rsz_idx] <= CODE_MAX;
      end else begin
        code_reg[rsz_idx] <= cfg.cfg_wdata[CODE_LSB +: CODE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Window bases
  // Bits under the mask are scrubbed every cycle, so bits that
  // turn read-only by a resize or page change come back as zero
  // and the old base is left meaningless until rewritten
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= {NUM_WIN{BASE_RST}};
    end else begin
      for (int i = 0; i < NUM_WIN; i++) begin
        if (wr && win_hit && win_idx == 3'(i)) begin
          base_reg[i] <= cfg.cfg_wdata & ~ro_mask[i] & ~TYPE_MASK;
        end else begin
          base_reg[i] <= base_reg[i] & ~ro_mask[i] & ~TYPE_MASK;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-function reset
  // Acknowledged only; windows, enable and codes are untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vf_done_reg <= 1'b0;
    end else begin
      vf_done_reg <= per_function_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // User outputs
  // Held bases are scrubbed on the edge after a mask change; mask includes type bits
  always_comb begin
    for (int i = 0; i < NUM_WIN; i++) begin
      vf_window_base_n[i] = base_reg[i];
      vf_window_mask[i]   = ro_mask[i] | TYPE_MASK;
    end
  end

  assign vf_reset_done          = vf_done_reg;
  assign vf_memory_space_enable = ctrl_reg[MSE_BIT];
endmodule

// ===== hw/vfr_host.sv
// Requester end: APB command registers driving config accesses
`timescale 1ns/10ps
module vfr_host
  import vfr_pkg::*;
(
  vfr_cfg_if.host     cfg,      // Config port
  input  wire logic   clk,      // 25 MHz clock
  input  wire logic   rst_n,    // Async reset
  input  wire logic   psel,     // APB select
  input  wire logic   penable,  // APB access phase
  input  wire logic   pwrite,   // APB direction
  input  wire logic [11:0] paddr,  // APB byte address
  input  wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata,   // APB read data
  output logic        pready,   // APB ready
  output logic        pslverr   // APB error
);
  typedef enum logic [1:0] {
    VFR_IDLE = 2'b01,
    VFR_WAIT = 2'b10
  } vfr_state_e;

  vfr_state_e  state_reg;
  logic [11:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic        wr_reg;
  logic        cfg_err_reg;
  logic        mse_err_reg;
  logic        page_warn_reg;
  logic        base_pend_reg;
  logic        mse_shadow;
  logic        page_done;
  logic [31:0] prdata_reg;
  logic        apb_wr;
  logic        go;
  logic        go_wr;
  logic        blocked;
  logic        done;
  logic        is_rsz;
  logic        is_win;
  logic        is_ctl;
  logic [31:0] stat_val;

  ////////////////////////////////////////////////////////////////////////
  // APB side
  assign apb_wr  = psel & penable & pwrite;
  assign go      = apb_wr && paddr == H_CMD && pwdata[CMD_GO]
                   && state_reg == VFR_IDLE;
  assign go_wr   = pwdata[CMD_WR];
  assign done    = state_reg == VFR_WAIT && cfg.cfg_ack;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(paddr == H_ADDR || paddr == H_WDATA
                   || paddr == H_CMD || paddr == H_STAT
                   || paddr == H_RDATA);

  // Resize slot and window address classes
  assign is_rsz = addr_reg >= OFF_RSZ_CAP0 && addr_reg < OFF_RSZ_CAP0
                  + RSZ_STRIDE * 12'(NUM_RSZ);
  assign is_win = addr_reg >= OFF_WIN0 && addr_reg <= OFF_WIN_LAST;
  // Control words share the low bits of the first control offset;
  // bit 2 alone would pick the capability words instead
  assign is_ctl = is_rsz && addr_reg[2:0] == OFF_RSZ_CTRL0[2:0];
  // Resize writes refused while memory decode is on
  assign blocked = go_wr && is_ctl && mse_shadow;

  assign stat_val = {27'h0, base_pend_reg, page_warn_reg, mse_err_reg,
                     cfg_err_reg, state_reg == VFR_WAIT};

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        H_ADDR:  prdata_reg <= {20'h0, addr_reg};
        H_WDATA: prdata_reg <= wdata_reg;
        H_STAT:  prdata_reg <= stat_val;
        H_RDATA: prdata_reg <= rdata_reg;
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_reg;

  // Address and data held steady while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg  <= 12'h000;
      wdata_reg <= 32'h0000_0000;
    end else if (apb_wr && state_reg == VFR_IDLE) begin
      if (paddr == H_ADDR) addr_reg <= pwdata[11:0];
      if (paddr == H_WDATA) wdata_reg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= VFR_IDLE;
      wr_reg    <= 1'b0;
    end else begin
      case (state_reg)
        VFR_IDLE: begin
          if (go && !blocked) begin
            state_reg <= VFR_WAIT;
            wr_reg    <= go_wr;
          end
        end
        VFR_WAIT: begin
          if (cfg.cfg_ack) state_reg <= VFR_IDLE;
        end
        default: state_reg <= VFR_IDLE;
      endcase
    end
  end

  assign cfg.cfg_req   = state_reg == VFR_WAIT && !cfg.cfg_ack;
  assign cfg.cfg_write = wr_reg;
  assign cfg.cfg_addr  = addr_reg;
  assign cfg.cfg_wdata = wdata_reg;

  // Completion capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (done && !wr_reg) begin
      rdata_reg <= cfg.cfg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shadows of function state seen in completed writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mse_shadow <= 1'b0;
      page_done  <= 1'b0;
    end else if (done && wr_reg) begin
      if (addr_reg == OFF_VF_CTRL) mse_shadow <= wdata_reg[MSE_BIT];
      if (addr_reg == OFF_PAGE_SIZE) page_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear (base pending cleared by a window write); a new set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_err_reg   <= 1'b0;
      mse_err_reg   <= 1'b0;
      page_warn_reg <= 1'b0;
      base_pend_reg <= 1'b0;
    end else begin
      if (done && cfg.cfg_err) begin
        cfg_err_reg <= 1'b1;
      end else if (apb_wr && paddr == H_STAT && pwdata[ST_CFG_ERR]) begin
        cfg_err_reg <= 1'b0;
      end
      if (go && blocked) begin
        mse_err_reg <= 1'b1;
      end else if (apb_wr && paddr == H_STAT && pwdata[ST_MSE_ERR]) begin
        mse_err_reg <= 1'b0;
      end
      if (done && is_rsz && !page_done) begin
        page_warn_reg <= 1'b1;
      end else if (apb_wr && paddr == H_STAT && pwdata[ST_PAGE_WARN]) begin
        page_warn_reg <= 1'b0;
      end
      // Base owed after a resize, paid by a window write
      if (done && wr_reg && is_ctl) begin
        base_pend_reg <= 1'b1;
      end else if (done && wr_reg && is_win) begin
        base_pend_reg <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/vfr_cfg_monitor.sv
// Protocol and content checker for the config channel
`timescale 1ns/10ps
module vfr_cfg_monitor
  import vfr_pkg::*;
(
  input wire logic        clk,       // Function clock
  input wire logic        rst_n,     // Async reset
  input wire logic        cfg_req,   // Request level
  input wire logic        cfg_write, // Direction
  input wire logic [11:0] cfg_addr,  // Byte address
  input wire logic [31:0] cfg_wdata, // Write data
  input wire logic [31:0] cfg_rdata, // Read data
  input wire logic        cfg_ack,   // Completion pulse
  input wire logic        cfg_err    // Unmapped flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // A request is taken only while no ack stands
  sequence s_take;
    cfg_req && !cfg_ack;
  endsequence
  sequence s_rd(logic [11:0] a);
    s_take ##0 (!cfg_write && cfg_addr == a);
  endsequence
  // Handshake timing; write effect lands on the taking edge
  a_ack_follows: assert property (s_take |=> cfg_ack)
    else $error("ack missing after take");
  a_ack_pulse: assert property (cfg_ack |=> !cfg_ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (cfg_ack |->
    $past(cfg_req) && !$past(cfg_ack))
    else $error("ack without request");
  a_req_drop: assert property (cfg_ack |-> !cfg_req)
    else $error("request held into ack");
  // Fixed content of the capability block and of the window type bits
  a_hdr_fixed: assert property (s_rd(OFF_RSZ_HDR) |=>
    cfg_rdata == {CAP_ID, CAP_VER, CAP_NEXT} && !cfg_err)
    else $error("header value wrong");
  a_cap_sizes: assert property (s_rd(OFF_RSZ_CAP0) |=>
    cfg_rdata == RSZ_CAP_VAL)
    else $error("advertised sizes wrong");
  a_sel_fixed: assert property (s_rd(OFF_RSZ_CTRL0 + RSZ_STRIDE)
    |=> cfg_rdata[2:0] == 3'h1 && cfg_rdata[31:14] == 18'h0)
    else $error("second selector wrong");
  a_code_range: assert property (s_rd(OFF_RSZ_CTRL0) |=>
    cfg_rdata[13:8] <= CODE_MAX && cfg_rdata[7:0] == 8'h40)
    else $error("first control word wrong");
  a_win_type: assert property (s_take ##0 (!cfg_write &&
    cfg_addr inside {[OFF_WIN0:OFF_WIN_LAST]}) |=>
    cfg_rdata[3:0] == 4'h0)
    else $error("window type bits not zero");
endmodule

// ===== verification/tb.sv
// Self-checking bench for the resize block and its requester
`timescale 1ns/10ps
module tb;
  import vfr_pkg::*;
  logic                     clk;
  logic                     rst_n;
  logic                     pfr;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     done;
  logic                     mse;
  logic [NUM_WIN-1:0][31:0] base;
  logic [NUM_WIN-1:0][31:0] wmask;
  logic                     chk;
  logic                     bad;
  logic [31:0]              rd;
  logic [31:0]              rnd;
  logic [31:0]              msk;
  logic [63:0]              note;
  logic [63:0]              exp_q[$];
  int                       failures;
  int                       num_checks;
  int                       pb;
  int                       wc;
  int                       code;
  int                       lg;
  ////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  vfr_cfg_if i_vfr_cfg_if (.clk(clk), .rst_n(rst_n));
  vfr_dev i_vfr_dev (.cfg(i_vfr_cfg_if), .clk(clk), .rst_n(rst_n),
    .per_function_reset(pfr), .vf_reset_done(done),
    .vf_memory_space_enable(mse), .vf_window_base_n(base),
    .vf_window_mask(wmask));
  vfr_host i_vfr_host (.cfg(i_vfr_cfg_if), .clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  vfr_cfg_monitor i_vfr_cfg_monitor (.clk(clk), .rst_n(rst_n),
    .cfg_req(i_vfr_cfg_if.cfg_req), .cfg_write(i_vfr_cfg_if.cfg_write),
    .cfg_addr(i_vfr_cfg_if.cfg_addr),
    .cfg_wdata(i_vfr_cfg_if.cfg_wdata),
    .cfg_rdata(i_vfr_cfg_if.cfg_rdata), .cfg_ack(i_vfr_cfg_if.cfg_ack),
    .cfg_err(i_vfr_cfg_if.cfg_err));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Masked compare; unknown bits never match
  task automatic cmp(input string nm, input logic [31:0] e, g, m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e & m, g & m);
    end
  endtask
  task automatic hang(input logic c);
    if (c) begin
      failures++;
      tally_and_finish();
    end
  endtask
  // One APB transfer, then an idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic c, input logic b);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    bad <= b;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hang(pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk <= 1'b0;
    bad <= 1'b0;
    @(posedge clk);
  endtask
  // Config access through the requester; rd ends holding status
  task automatic cfg(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    apb(1'b1, H_ADDR, {20'h0_0000, a}, 1'b0, 1'b0);
    apb(1'b1, H_WDATA, d, 1'b0, 1'b0);
    apb(1'b1, H_CMD, {30'h0, w, 1'b1}, 1'b0, 1'b0);
    n = 0;
    do begin
      apb(1'b0, H_STAT, 32'h0, 1'b0, 1'b0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 20);
    hang(rd[ST_BUSY] !== 1'b0);
  endtask
  // Note the expectation, then fetch the read data
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, m);
    cfg(1'b0, a, 32'h0);
    exp_q.push_back({m, e});
    apb(1'b0, H_RDATA, 32'h0, 1'b1, 1'b0);
  endtask
  // Watcher: each checked read takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && chk) begin
      note = exp_q.pop_front();
      cmp("rdata", note[31:0], prdata, note[63:32]);
    end
    if (psel && penable && pready && bad)
      cmp("pslverr", 32'h1, {31'h0, pslverr}, 32'h1);
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    pfr = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    chk = 1'b0;
    bad = 1'b0;
    failures = 0;
    num_checks = 0;
    rnd = 32'h0000_6E2F;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Defaults behave as a plain 1 MB window
    cmp("mask0", 32'h000F_FFFF, wmask[0], '1);
    rdchk(OFF_RSZ_HDR, 32'h0241_0000, '1);
    rdchk(OFF_RSZ_CAP0, RSZ_CAP_VAL, '1);
    rdchk(OFF_RSZ_CTRL0, 32'h0000_0040, '1);
    rdchk(OFF_RSZ_CTRL0 + RSZ_STRIDE, 32'h0000_0001, '1);
    cfg(1'b1, OFF_WIN0, '1);
    rdchk(OFF_WIN0, 32'hFFF0_0000, '1);
    // Random page size against size code; last pass clips a code
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      pb = rnd[3:0] % 12;
      wc = (i == 7) ? 63 : rnd[10:8];
      code = (wc > 43) ? 43 : wc;
      lg = (12 + pb > 20 + code) ? 12 + pb : 20 + code;
      msk = (lg >= 32) ? '1 : (32'h1 << lg) - 32'h1;
      cfg(1'b1, OFF_VF_CTRL, 32'h0);
      cfg(1'b1, OFF_PAGE_SIZE, 32'h1 << pb);
      cfg(1'b1, OFF_WIN0, '1);
      cfg(1'b1, OFF_RSZ_CTRL0, 32'(wc) << CODE_LSB);
      cmp("pend", 32'h10, rd, 32'h10);
      rdchk(OFF_WIN0, 32'h0, msk);
      cmp("wmask", msk, wmask[0], '1);
      cmp("wmask2", (pb > 8) ? (32'h1 << (12 + pb)) - 32'h1 : 32'h000F_FFFF,
          wmask[2], '1);
      cfg(1'b1, OFF_WIN0, '1);
      cmp("pend", 32'h0, rd, 32'h10);
      rdchk(OFF_WIN0, ~msk, '1);
      rdchk(OFF_RSZ_CTRL0, 32'(code) << 8, 32'h3F00);
    end
    // Refused resize while decode is on; state kept over VF reset
    cfg(1'b1, OFF_RSZ_CTRL0, 32'h0);
    cfg(1'b1, OFF_PAGE_SIZE, 32'h1);
    cfg(1'b1, OFF_WIN0, 32'hA000_0000);
    cfg(1'b1, OFF_VF_CTRL, 32'h0000_0008);
    cfg(1'b1, OFF_RSZ_CTRL0, 32'h0000_0300);
    cmp("order", 32'h4, rd, 32'h4);
    pfr <= 1'b1;
    @(posedge clk);
    pfr <= 1'b0;
    @(posedge clk);
    // Sampled before this edge's update: still the launched pulse
    cmp("done", 32'h1, {31'h0, done}, 32'h1);
    rdchk(OFF_RSZ_CTRL0, 32'h0, 32'h3F00);
    rdchk(OFF_WIN0, 32'hA000_0000, '1);
    cmp("mse", 32'h1, {31'h0, mse}, 32'h1);
    cmp("base0", 32'hA000_0000, base[0], '1);
    apb(1'b0, 12'h0FC, 32'h0, 1'b0, 1'b1);
    hang(exp_q.size() != 0);
    tally_and_finish();
  end
endmodule
